// ### rtl/lmaac_regs.vh
`ifndef LMAAC_REGS_VH
`define LMAAC_REGS_VH
// ==========================================================================
// mode codes of the latched control word {b0,b1,b2}
`define LMAAC_MODE_PDOWN      3'b000
`define LMAAC_MODE_RING       3'b001
`define LMAAC_MODE_OHT_REV    3'b010
`define LMAAC_MODE_OHT_DIR    3'b011
`define LMAAC_MODE_ACT_REV    3'b110
`define LMAAC_MODE_ACT_DEF    3'b100
// ==========================================================================
// control word reset value and field positions
`define LMAAC_CTL_RESET       5'h00
`define LMAAC_CTL_B0          4
`define LMAAC_CTL_B1          3
`define LMAAC_CTL_B2          2
`define LMAAC_CTL_RA          1
`define LMAAC_CTL_RB          0
// ==========================================================================
// timing
`define LMAAC_CLK_NS          100
`define LMAAC_RING_LOW_NS     1000
`define LMAAC_RING_LOW_CYC    8'h0A // 1 us low phase at the 100 ns clock
`define LMAAC_SYNC_LAT        8'h03 // pin to synced-copy delay in edges
`define LMAAC_ONHOOK_PERIODS  8'h80
`define LMAAC_CHECK_PERIODS   8'h02
`endif

// ### rtl/lmaac_sync2.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// two-stage level synchroniser
module lmaac_sync2 (
    input  wire core_clk,
    input  wire reset,
    input  wire din,
    output reg  dout
);
    reg stage1;

    // first stage feeds only the second
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule
`default_nettype wire

// ### rtl/lmaac_period_cnt.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// counts ring clock periods while enabled, flags reaching a limit
module lmaac_period_cnt (
    input  wire       core_clk,
    input  wire       reset,
    input  wire       run,
    input  wire       tick,
    input  wire [7:0] limit,
    output wire       done
);
    reg [7:0] count;

    assign done = (count >= limit);

    // clears when stopped, saturates at limit
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= 8'h00;
        end else if (!run) begin
            count <= 8'h00;
        end else if (tick && !done) begin
            count <= count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### rtl/lmaac_ctrl.v
// How it works
// - clear high: mode bits give power down, ringing, on-hook or active modes
// - clear low forces power down, relays off, status outputs disabled
// - relay bits drive test relays directly and never change status
// - hook status goes low with fault output on alarm or ground-key
// - fault output disabled in ringing and power down unless thermal or overvoltage, reports otherwise
// - separate active-low selects latch input and enable output
// - input select low captures the bus; controller holds bits valid
// - output select high tri-states both status outputs
// - power down disables line, only test relays stay controllable
// - reset idle drops relays and status; thermal idle forces status low
// - ringing turns relay on; ring-trip drops relay and hook status
// - ring-trip hook low stays latched until mode changes
// - ringing relay only switches on during a ringing clock low
// - on-hook transmission keeps conversation state, no fallback
// - active code lets the device pick hi-z, stand-by or active
// - hi-z entered after reset or active code, always direct polarity
// - off-hook in hi-z checked in stand-by, then active or back
// - hook status follows loop in real time while active
// - active, except reverse active, falls back after on-hook longer than 128 ring periods
// - state machine runs on the free-running internal clock
// - overvoltage sense drives both status outputs low, mode unchanged
`timescale 1ns/100ps
`default_nettype none
`include "lmaac_regs.vh"
module lmaac_ctrl (
    input  wire core_clk,
    input  wire reset,
    input  wire chip_clear_n,
    input  wire input_latch_select_n,
    input  wire output_enable_select_n,
    input  wire line_mode_b0,
    input  wire line_mode_b1,
    input  wire line_mode_b2,
    input  wire test_relay_a_ctl,
    input  wire test_relay_b_ctl,
    input  wire ring_sync_clock,
    input  wire offHookIn,
    input  wire ringTripIn,
    input  wire groundKeyIn,
    input  wire thermalAlarmIn,
    input  wire lineFaultIn,
    input  wire overvoltage_sense_in,
    output reg  hook_status_n_out,
    output reg  hook_status_n_oe,
    output reg  fault_alarm_n_out,
    output reg  fault_alarm_n_oe,
    output reg  test_relay_a,
    output reg  test_relay_b,
    output reg  ringing_relay_drive,
    output reg  lineEnable,
    output reg  reversePolarity,
    output reg  feedHiZ,
    output reg  feedStandby,
    output reg  feedActive
);
    // ======================================================================
    // states, one-hot
    localparam [3:0] ST_HIZ  = 4'b0001;
    localparam [3:0] ST_STBY = 4'b0010;
    localparam [3:0] ST_ACT  = 4'b0100;
    localparam [3:0] ST_MAN  = 4'b1000;
    localparam [7:0] RING_LOW_CYC = `LMAAC_RING_LOW_CYC;
    // relay may only rise while the pin is surely still low
    localparam [7:0] RING_ON_WIN  = RING_LOW_CYC - `LMAAC_SYNC_LAT;

    // ======================================================================
    // pin synchronisers
    wire clearSync;
    wire latchSelSync;
    wire outSelSync;
    wire ringClkSync;
    wire offHookSync;
    wire ringTripSync;
    wire gndKeySync;
    wire thermalSync;
    wire faultSync;
    wire ovSync;
    wire [4:0] busSync;
    wire [14:0] pinBus;
    wire [14:0] syncBus;

    // pin order here fixes how the synced bus is split below
    assign pinBus = {chip_clear_n, input_latch_select_n, output_enable_select_n,
                     ring_sync_clock, offHookIn, ringTripIn, groundKeyIn,
                     thermalAlarmIn, lineFaultIn, overvoltage_sense_in,
                     line_mode_b0, line_mode_b1, line_mode_b2,
                     test_relay_a_ctl, test_relay_b_ctl};
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi = gi + 1) begin : gSync
            lmaac_sync2 uSync (
                .core_clk (core_clk),
                .reset    (reset),
                .din      (pinBus[gi]),
                .dout     (syncBus[gi])
            );
        end
    endgenerate
    assign {clearSync, latchSelSync, outSelSync, ringClkSync, offHookSync,
            ringTripSync, gndKeySync, thermalSync, faultSync, ovSync} = syncBus[14:5];
    assign busSync = syncBus[4:0];

    // ======================================================================
    // control latch
    reg  [4:0] ctlWord;
    wire [2:0] mode;
    wire       modeWritten;
    reg  [2:0] lastMode;
    reg        anyWrite;

    // bus and select share one sync delay, so the bits line up
    // capture while input select low
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctlWord <= `LMAAC_CTL_RESET;
        end else if (!latchSelSync) begin
            ctlWord <= busSync;
        end
    end
    assign mode = {ctlWord[`LMAAC_CTL_B0], ctlWord[`LMAAC_CTL_B1], ctlWord[`LMAAC_CTL_B2]};

    // mode change detect
    // pulses on a code change and at the end of every latch strobe
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lastMode <= `LMAAC_MODE_PDOWN;
            anyWrite <= 1'b0;
        end else begin
            lastMode <= mode;
            anyWrite <= !latchSelSync;
        end
    end
    assign modeWritten = (mode != lastMode) || (anyWrite && latchSelSync);

    // ======================================================================
    // mode decode
    wire isPdown;
    wire isRing;
    wire isOht;
    wire isActive;
    wire isDefault;
    wire wantRev;

    assign isPdown   = !clearSync || (mode == `LMAAC_MODE_PDOWN);
    assign isRing    = clearSync && (mode == `LMAAC_MODE_RING);
    assign isOht     = clearSync && (mode == `LMAAC_MODE_OHT_REV || mode == `LMAAC_MODE_OHT_DIR);
    assign isActive  = clearSync && mode[2];
    assign isDefault = isActive && (mode != `LMAAC_MODE_ACT_REV);
    assign wantRev   = (mode == `LMAAC_MODE_OHT_REV) || (mode == `LMAAC_MODE_ACT_REV);

    // ======================================================================
    // ringing clock edges and low-phase width
    reg        ringClkDly;
    reg  [7:0] lowCount;
    wire       ringTick;
    wire       ringLowOk;

    // synced rising edge marks one ring clock period
    assign ringTick  = ringClkSync && !ringClkDly;
    // synced copy lags the pin, so only an early part of a low phase
    // is safe: a late start could switch the relay after the pin rose
    assign ringLowOk = !ringClkSync && (lowCount < RING_ON_WIN);

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ringClkDly <= 1'b0;
            lowCount   <= 8'h00;
        end else begin
            ringClkDly <= ringClkSync;
            if (ringClkSync) begin
                lowCount <= 8'h00;
            end else if (lowCount != 8'hFF) begin
                lowCount <= lowCount + 8'h01;
            end
        end
    end

    // ======================================================================
    // automatic activation state machine
    reg  [3:0] state;
    reg  [3:0] next_state;
    wire       onHookLong;
    wire       checkDone;

    // both counters clear whenever their state is left
    // on-hook persistence
    lmaac_period_cnt uOnHook (
        .core_clk (core_clk),
        .reset    (reset),
        .run      ((state == ST_ACT) && !offHookSync),
        .tick     (ringTick),
        .limit    (`LMAAC_ONHOOK_PERIODS),
        .done     (onHookLong)
    );

    lmaac_period_cnt uCheck (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (state == ST_STBY),
        .tick     (ringTick),
        .limit    (`LMAAC_CHECK_PERIODS),
        .done     (checkDone)
    );

    // any write of an active code restarts at hi-z
    // next-state logic
    always @* begin
        next_state = state;
        case (state)
            ST_HIZ: begin
                if (!isActive) next_state = ST_MAN;
                else if (offHookSync) next_state = ST_STBY;
            end
            ST_STBY: begin
                if (!isActive) next_state = ST_MAN;
                else if (checkDone) next_state = offHookSync ? ST_ACT : ST_HIZ;
            end
            ST_ACT: begin
                if (!isActive) next_state = ST_MAN;
                else if (modeWritten) next_state = ST_HIZ;
                else if (onHookLong && isDefault) next_state = ST_HIZ;
            end
            ST_MAN: begin
                if (isActive) next_state = ST_HIZ;
            end
            default: next_state = ST_HIZ;
        endcase
    end

    // a fresh active code wins over the next-state choice
    // hi-z after reset, internal clock
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ST_HIZ;
        end else if (isActive && modeWritten) begin
            state <= ST_HIZ;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================================
    // ring-trip latch and ringing relay
    reg tripLatched;

    // rewriting the ringing code keeps the trip, only a new mode clears it
    // latch trip until mode changes
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tripLatched <= 1'b0;
        end else if (!isRing) begin
            tripLatched <= 1'b0;
        end else if (ringTripSync) begin
            tripLatched <= 1'b1;
        end
    end

    // ======================================================================
    // status and drive decode
    reg next_hook;
    reg next_fault;
    reg next_oe;
    reg next_faultOe;
    wire alarmAny;

    // outside ringing and power down, any fault source pulls both status values low
    assign alarmAny = thermalSync || gndKeySync || faultSync || ovSync;

    // thermal and overvoltage win over the mode, select still tri-states
    // status values
    always @* begin
        next_hook    = 1'b1;
        next_fault   = 1'b1;
        next_oe      = 1'b1;
        next_faultOe = 1'b1;
        if (!clearSync) begin
            next_oe      = 1'b0;
            next_faultOe = 1'b0;
        end else if (thermalSync || ovSync) begin
            next_hook  = 1'b0;
            next_fault = 1'b0;
        end else if (isPdown) begin
            next_oe      = 1'b0;
            next_faultOe = 1'b0;
        end else if (isRing) begin
            next_hook    = !tripLatched;
            next_faultOe = 1'b0;
        end else begin
            next_hook  = !offHookSync && !alarmAny;
            next_fault = !alarmAny;
        end
        if (outSelSync) begin
            next_oe      = 1'b0;
            next_faultOe = 1'b0;
        end
    end

    // relays follow their bits unless clear is low
    // registered outputs
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hook_status_n_out   <= 1'b1;
            hook_status_n_oe    <= 1'b0;
            fault_alarm_n_out   <= 1'b1;
            fault_alarm_n_oe    <= 1'b0;
            test_relay_a        <= 1'b0;
            test_relay_b        <= 1'b0;
            ringing_relay_drive <= 1'b0;
            lineEnable          <= 1'b0;
            reversePolarity     <= 1'b0;
            feedHiZ             <= 1'b0;
            feedStandby         <= 1'b0;
            feedActive          <= 1'b0;
        end else begin
            hook_status_n_out <= next_hook;
            hook_status_n_oe  <= next_oe;
            fault_alarm_n_out <= next_fault;
            fault_alarm_n_oe  <= next_faultOe;
            test_relay_a      <= clearSync && ctlWord[`LMAAC_CTL_RA];
            test_relay_b      <= clearSync && ctlWord[`LMAAC_CTL_RB];
            if (!isRing || tripLatched || ringTripSync || thermalSync) begin
                ringing_relay_drive <= 1'b0;
            end else if (ringLowOk) begin
                ringing_relay_drive <= 1'b1;
            end
            lineEnable      <= !isPdown && !thermalSync;
            reversePolarity <= wantRev && !(isActive && state == ST_HIZ);
            feedHiZ         <= isActive && (state == ST_HIZ);
            feedStandby     <= isActive && (state == ST_STBY);
            feedActive      <= (isActive && state == ST_ACT) || isOht;
        end
    end
endmodule
`default_nettype wire

// ### verif/lmaac_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// checker on the control block ports
module lmaac_ctrl_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_clear_n,
    input wire logic output_enable_select_n,
    input wire logic ring_sync_clock,
    input wire logic offHookIn,
    input wire logic ringTripIn,
    input wire logic groundKeyIn,
    input wire logic lineFaultIn,
    input wire logic thermalAlarmIn,
    input wire logic overvoltage_sense_in,
    input wire logic hook_status_n_out,
    input wire logic hook_status_n_oe,
    input wire logic fault_alarm_n_out,
    input wire logic fault_alarm_n_oe,
    input wire logic test_relay_a,
    input wire logic test_relay_b,
    input wire logic ringing_relay_drive,
    input wire logic reversePolarity,
    input wire logic feedHiZ,
    input wire logic feedStandby,
    input wire logic feedActive
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // relay on, then trip held
    sequence s_trip;
        ringing_relay_drive ##1 ringTripIn [*5];
    endsequence
    AST_CLEAR_OFF: assert property (
        !chip_clear_n [*6] |-> !(test_relay_a || test_relay_b || hook_status_n_oe))
        else $error("clear low but outputs on");
    AST_OE_HIZ: assert property (
        output_enable_select_n [*6] |-> !hook_status_n_oe && !fault_alarm_n_oe)
        else $error("status driven while select high");
    AST_RING_LOW: assert property (
        $rose(ringing_relay_drive) |-> !ring_sync_clock && !$past(ring_sync_clock, 3))
        else $error("ring relay rose outside ring clock low");
    AST_TRIP_DROP: assert property (
        s_trip |-> !ringing_relay_drive && !hook_status_n_out)
        else $error("ring trip did not drop relay");
    AST_SB_BOUND: assert property (
        $rose(feedStandby) |-> ##[1:130] !feedStandby)
        else $error("standby check too long");
    AST_HIZ_WAKE: assert property (
        (feedHiZ && offHookIn) [*3] |-> ##[1:3] feedStandby)
        else $error("off-hook in hi-z did not reach standby");
    AST_ACT_OFF: assert property (
        (feedActive && offHookIn) [*4] |-> !hook_status_n_out)
        else $error("active off-hook not signalled");
    AST_ACT_ON: assert property (
        (feedActive && !offHookIn && !groundKeyIn && !lineFaultIn
            && !thermalAlarmIn && !overvoltage_sense_in) [*4] |-> hook_status_n_out)
        else $error("active on-hook not signalled");
    AST_FAULT_LOW: assert property (
        (chip_clear_n && (overvoltage_sense_in || thermalAlarmIn)) [*4]
            |-> !hook_status_n_out && !fault_alarm_n_out)
        else $error("fault did not force status low");
    AST_HIZ_DIRECT: assert property (
        feedHiZ |-> !reversePolarity)
        else $error("reverse polarity in hi-z feeding");
endmodule
bind lmaac_ctrl lmaac_ctrl_props i_props (
    .core_clk, .reset, .chip_clear_n, .output_enable_select_n, .ring_sync_clock,
    .offHookIn, .ringTripIn, .groundKeyIn, .lineFaultIn, .thermalAlarmIn,
    .overvoltage_sense_in, .hook_status_n_out,
    .hook_status_n_oe, .fault_alarm_n_out, .fault_alarm_n_oe, .test_relay_a, .test_relay_b,
    .ringing_relay_drive, .reversePolarity, .feedHiZ, .feedStandby, .feedActive
);
`default_nettype wire

// ### verif/lmaac_line_card.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// line card side: control bus and ring clock
module lmaac_line_card (
    input  wire logic core_clk,
    output wire logic input_latch_select_n,
    output wire logic line_mode_b0,
    output wire logic line_mode_b1,
    output wire logic line_mode_b2,
    output wire logic test_relay_a_ctl,
    output wire logic test_relay_b_ctl,
    output wire logic ring_sync_clock
);
    logic [4:0] busWord  = 5'h00;
    logic       selN     = 1'b1;
    int         ringStep = 0;
    logic       ringClk  = 1'b0;
    // bus pins from the word register
    assign {line_mode_b0, line_mode_b1, line_mode_b2, test_relay_a_ctl, test_relay_b_ctl} = busWord;
    assign input_latch_select_n = selN;
    assign ring_sync_clock      = ringClk;
    always @(posedge core_clk) begin
        ringStep <= (ringStep + 1) % 40;
        ringClk <= (ringStep >= 20); // 2 us low
    end
    task automatic write_word(input logic [4:0] word);
        @(posedge core_clk);
        busWord <= word;
        selN <= 1'b0;
        repeat (4) @(posedge core_clk);
        selN <= 1'b1;
        repeat (2) @(posedge core_clk);
        busWord <= 5'h00; // released bus is pulled down
    endtask
endmodule
`default_nettype wire

// ### verif/lmaac_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// self-checking bench of the control block
module lmaac_ctrl_tb_top;
    logic core_clk = 1'b0;
    logic reset    = 1'b1;
    logic chip_clear_n, output_enable_select_n, offHookIn, ringTripIn;
    logic groundKeyIn, thermalAlarmIn, lineFaultIn, overvoltage_sense_in;
    logic input_latch_select_n, line_mode_b0, line_mode_b1, line_mode_b2;
    logic test_relay_a_ctl, test_relay_b_ctl, ring_sync_clock;
    logic hook_status_n_out, hook_status_n_oe, fault_alarm_n_out, fault_alarm_n_oe;
    logic test_relay_a, test_relay_b, ringing_relay_drive, lineEnable;
    logic reversePolarity, feedHiZ, feedStandby, feedActive;
    int   num_errors = 0;
    int   checks     = 0;
    int   seed       = 32'h9e0e;
    // ==========================================
    // clock, design and line card
    always #50 core_clk = ~core_clk;
    lmaac_ctrl i_dut (
        .core_clk, .reset, .chip_clear_n, .input_latch_select_n, .output_enable_select_n,
        .line_mode_b0, .line_mode_b1, .line_mode_b2, .test_relay_a_ctl, .test_relay_b_ctl,
        .ring_sync_clock, .offHookIn, .ringTripIn, .groundKeyIn, .thermalAlarmIn, .lineFaultIn,
        .overvoltage_sense_in, .hook_status_n_out, .hook_status_n_oe, .fault_alarm_n_out,
        .fault_alarm_n_oe, .test_relay_a, .test_relay_b, .ringing_relay_drive, .lineEnable,
        .reversePolarity, .feedHiZ, .feedStandby, .feedActive
    );
    lmaac_line_card i_card (
        .core_clk, .input_latch_select_n, .line_mode_b0, .line_mode_b1, .line_mode_b2,
        .test_relay_a_ctl, .test_relay_b_ctl, .ring_sync_clock
    );
    // ==========================================
    // compare, model and helpers
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // expected relays and status enables
    function automatic logic [3:0] exp_static(int code, int clr, int oeN, int ctl);
        if (clr == 0)
            return 4'h0;
        return {ctl[1], ctl[0], oeN == 0 && code != 0, oeN == 0 && code > 1};
    endfunction
    task automatic wait_high(ref logic sig, input int lim);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog, tests need about 8400 cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        stop_test;
    end
    // ==========================================
    // main sequence
    initial begin
        int code;
        int ctl;
        {chip_clear_n, output_enable_select_n, offHookIn, ringTripIn} = 4'h8;
        {groundKeyIn, thermalAlarmIn, lineFaultIn, overvoltage_sense_in} = 4'h0;
        repeat (12) @(posedge core_clk);
        chk("resetIdle", 4'h0, {test_relay_a, test_relay_b, hook_status_n_oe, fault_alarm_n_oe});
        reset <= 1'b0;
        // every mode code, then select high, then clear low
        for (int i = 0; i < 24; i++) begin
            code = i % 8;
            ctl = $random(seed) & 3;
            chip_clear_n <= (i / 8) != 2;
            output_enable_select_n <= (i / 8) == 1;
            i_card.write_word({code[2:0], ctl[1:0]});
            repeat (8) @(posedge core_clk);
            chk("static", exp_static(code, i / 8 != 2, i / 8 == 1, ctl),
                {test_relay_a, test_relay_b, hook_status_n_oe, fault_alarm_n_oe});
            // line off in power down, on otherwise
            chk("lineEnable", (code == 0 || i / 8 == 2) ? 4'h0 : 4'h1, lineEnable);
            if (i < 8 && code > 1)
                chk("polFeed", {code == 2, code > 3}, {reversePolarity, feedHiZ});
        end
        chip_clear_n <= 1'b1;
        output_enable_select_n <= 1'b0;
        i_card.write_word(5'h04);
        wait_high(ringing_relay_drive, 100);
        chk("ringRelay", 4'h1, ringing_relay_drive);
        chk("ringClock", 4'h0, ring_sync_clock);
        ringTripIn <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("tripped", 4'h0, {ringing_relay_drive, hook_status_n_out});
        repeat (100) @(posedge core_clk);
        chk("tripLatch", 4'h0, {ringing_relay_drive, hook_status_n_out});
        ringTripIn <= 1'b0;
        i_card.write_word(5'h10);
        repeat (8) @(posedge core_clk);
        chk("hookRelease", 4'h1, hook_status_n_out);
        offHookIn <= 1'b1;
        repeat (3) @(posedge core_clk);
        offHookIn <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("standby", 4'h1, feedStandby);
        repeat (147) @(posedge core_clk);
        chk("spurious", 4'h1, feedHiZ);
        offHookIn <= 1'b1;
        wait_high(feedActive, 150);
        repeat (4) @(posedge core_clk);
        chk("active", 4'h2, {feedActive, hook_status_n_out});
        offHookIn <= 1'b0;
        repeat (2400) @(posedge core_clk);
        offHookIn <= 1'b1;
        repeat (10) @(posedge core_clk);
        offHookIn <= 1'b0;
        repeat (5040) @(posedge core_clk);
        chk("stillActive", 4'h1, feedActive);
        wait_high(feedHiZ, 160);
        chk("fallback", 4'h1, feedHiZ);
        for (int f = 0; f < 4; f++) begin
            {groundKeyIn, lineFaultIn, thermalAlarmIn, overvoltage_sense_in} <= 4'h8 >> f;
            repeat (8) @(posedge core_clk);
            chk("faultLow", 4'h0, {hook_status_n_out, fault_alarm_n_out});
            if (f == 3)
                chk("modeKept", 4'h1, feedHiZ);
            {groundKeyIn, lineFaultIn, thermalAlarmIn, overvoltage_sense_in} <= 4'h0;
            repeat (8) @(posedge core_clk);
            chk("faultGone", 4'h3, {hook_status_n_out, fault_alarm_n_out});
        end
        stop_test;
    end
endmodule
`default_nettype wire
